// File: common/mode_ctrl_defs.svh
`ifndef MODE_CTRL_DEFS_SVH
`define MODE_CTRL_DEFS_SVH

// register index and reset value; mode field resets to continuous conversion
`define MODE_REG_ADDR      6'h01
`define DATA_REG_ADDR      6'h04
`define MODE_RESET_VAL     16'h2000
`define MODE_WR_MASK       16'hE7FC
// field positions
`define BIT_REF_EN         15
`define BIT_RAIL_EN        14
`define BIT_SETTLED        13
`define DELAY_HI           10
`define DELAY_LO           8
`define BIT_RATE_X2        7
`define MODE_HI            6
`define MODE_LO            4
`define CLKSEL_HI          3
`define CLKSEL_LO          2
`define BIT_SW_RESET       0
// channel switch delays in modulator periods
`define DLY_CODE0          13'h000E
`define DLY_CODE1          13'h0019
`define DLY_CODE2          13'h0040
`define DLY_CODE3          13'h0100
`define DLY_CODE4          13'h0400
`define DLY_CODE5          13'h0800
`define DLY_CODE6          13'h1000
`define DLY_CODE7          13'h0001
// software reset pulse length in clocks
`define SW_RESET_CYCLES    4'h4

`endif

// File: common/mode_ctrl_pkg.sv
package mode_ctrl_pkg;
   typedef enum logic [2:0] {
      MODE_CONT = 3'h0, MODE_SINGLE = 3'h1, MODE_STANDBY = 3'h2, MODE_RSVD = 3'h3,
      MODE_INT_OFS = 3'h4, MODE_RSVD5 = 3'h5, MODE_SYS_OFS = 3'h6, MODE_SYS_GAIN = 3'h7
   } conv_mode_e;
   typedef enum logic [1:0] {
      CLK_INT = 2'h0, CLK_INT_OUT = 2'h1, CLK_EXT = 2'h2, CLK_RSVD = 2'h3
   } clk_src_e;
endpackage

// File: common/settle_if.sv
`timescale 1ns/1ps
interface settle_if;
   logic        start;
   logic [12:0] periods;
   logic        busy;
   logic        done;
   modport ctrl (output start, output periods, input busy, input done);
   modport cnt  (input start, input periods, output busy, output done);
endinterface

// File: rtl/settle_counter.sv
`timescale 1ns/1ps
module settle_counter (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic modTick,
   settle_if.cnt     sif
);
   logic [12:0] count_ff;
   logic        busy_ff;

   // --------------------------------------------------------------
   // counts modulator ticks after a channel switch
   // --------------------------------------------------------------
   // restart wins over a running count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= 13'h0000;
         busy_ff  <= 1'b0;
      end else if (sif.start) begin
         count_ff <= sif.periods;
         busy_ff  <= 1'b1;
      end else if (busy_ff && modTick) begin
         count_ff <= count_ff - 13'h0001;
         if (count_ff == 13'h0001) begin
            busy_ff <= 1'b0;
         end
      end
   end

   assign sif.busy = busy_ff;
   assign sif.done = busy_ff && modTick && (count_ff == 13'h0001);
endmodule

// File: rtl/converter_mode_control.sv
`timescale 1ns/1ps
`include "mode_ctrl_defs.svh"
module converter_mode_control (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [5:0]  regAddr,
   input  wire logic [15:0] regWdata,
   output logic      [15:0] regRdata,
   input  wire logic        modTick,
   input  wire logic        channelSwitch,
   input  wire logic        resultWritten,
   output logic             refEnable,
   output logic             referenceOutputEnable,
   output logic             ampRailDetectEnable,
   output logic             settledOutputOnly,
   output logic             rateDouble,
   output logic      [2:0]  convMode,
   output logic      [1:0]  clockSourceSelect,
   output logic             intOscEnable,
   output logic             crystalClockOutEnable,
   output logic             extClockSelect,
   output logic             filterReset,
   output logic             convStart,
   output logic             settleBusy,
   output logic             settleDone,
   output logic             newResultReady,
   output logic             softwareResetPulse
);
   logic [15:0] mode_ff;
   logic        start_ff;
   logic        rdy_ff;
   logic [3:0]  swRst_ff;
   logic        modeWrite;
   logic        dataRead;
   logic [12:0] delayPeriods;
   logic        modeRuns;
   settle_if    sif ();

   assign modeWrite = regWrite && (regAddr == `MODE_REG_ADDR);
   assign dataRead  = regRead && (regAddr == `DATA_REG_ADDR);

   // --------------------------------------------------------------
   // mode register
   // --------------------------------------------------------------
   // whole word loads at once; reserved and reset bits masked off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= `MODE_RESET_VAL;
      end else if (swRst_ff != 4'h0) begin
         mode_ff <= `MODE_RESET_VAL;
      end else if (modeWrite) begin
         mode_ff <= regWdata & `MODE_WR_MASK;
      end
   end

   // --------------------------------------------------------------
   // software reset, self clearing
   // --------------------------------------------------------------
   // stretched a few cycles so the core sees a clean pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         swRst_ff <= 4'h0;
      end else if (modeWrite && regWdata[`BIT_SW_RESET]) begin
         swRst_ff <= `SW_RESET_CYCLES;
      end else if (swRst_ff != 4'h0) begin
         swRst_ff <= swRst_ff - 4'h1;
      end
   end
   assign softwareResetPulse = (swRst_ff != 4'h0);

   // --------------------------------------------------------------
   // restart after write
   // --------------------------------------------------------------
   // start follows filter reset one cycle later so the new mode is stored
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= modeWrite && !regWdata[`BIT_SW_RESET];
      end
   end
   assign filterReset = modeWrite;
   assign convStart   = start_ff && modeRuns;

   // --------------------------------------------------------------
   // mode decode
   // --------------------------------------------------------------
   // standby and reserved code 3 never start the core; reserved code 5 does
   always_comb begin
      case (mode_ctrl_pkg::conv_mode_e'(convMode))
         mode_ctrl_pkg::MODE_CONT:     modeRuns = 1'b1;
         mode_ctrl_pkg::MODE_SINGLE:   modeRuns = 1'b1;
         mode_ctrl_pkg::MODE_STANDBY:  modeRuns = 1'b0;
         mode_ctrl_pkg::MODE_RSVD:     modeRuns = 1'b0;
         mode_ctrl_pkg::MODE_INT_OFS:  modeRuns = 1'b1;
         mode_ctrl_pkg::MODE_RSVD5:    modeRuns = 1'b1;
         mode_ctrl_pkg::MODE_SYS_OFS:  modeRuns = 1'b1;
         mode_ctrl_pkg::MODE_SYS_GAIN: modeRuns = 1'b1;
         default:                      modeRuns = 1'b0;
      endcase
   end

   // --------------------------------------------------------------
   // new-result flag
   // --------------------------------------------------------------
   // a result landing with a read keeps the flag: set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdy_ff <= 1'b0;
      end else if (resultWritten) begin
         rdy_ff <= 1'b1;
      end else if (modeWrite || dataRead || softwareResetPulse) begin
         rdy_ff <= 1'b0;
      end
   end
   assign newResultReady = rdy_ff;

   // --------------------------------------------------------------
   // field decode
   // --------------------------------------------------------------
   assign refEnable             = mode_ff[`BIT_REF_EN];
   assign referenceOutputEnable = mode_ff[`BIT_REF_EN];
   assign ampRailDetectEnable   = mode_ff[`BIT_RAIL_EN];
   assign settledOutputOnly     = mode_ff[`BIT_SETTLED];
   assign rateDouble            = mode_ff[`BIT_RATE_X2];
   assign convMode              = mode_ff[`MODE_HI:`MODE_LO];
   assign clockSourceSelect     = mode_ff[`CLKSEL_HI:`CLKSEL_LO];

   // --------------------------------------------------------------
   // clock source decode
   // --------------------------------------------------------------
   // the reserved code falls back to the internal oscillator
   always_comb begin
      case (mode_ctrl_pkg::clk_src_e'(clockSourceSelect))
         mode_ctrl_pkg::CLK_INT: begin
            intOscEnable          = 1'b1;
            crystalClockOutEnable = 1'b0;
            extClockSelect        = 1'b0;
         end
         mode_ctrl_pkg::CLK_INT_OUT: begin
            intOscEnable          = 1'b1;
            crystalClockOutEnable = 1'b1;
            extClockSelect        = 1'b0;
         end
         mode_ctrl_pkg::CLK_EXT: begin
            intOscEnable          = 1'b0;
            crystalClockOutEnable = 1'b0;
            extClockSelect        = 1'b1;
         end
         default: begin
            intOscEnable          = 1'b1;
            crystalClockOutEnable = 1'b0;
            extClockSelect        = 1'b0;
         end
      endcase
   end

   // --------------------------------------------------------------
   // channel switch delay
   // --------------------------------------------------------------
   always_comb begin
      case (mode_ff[`DELAY_HI:`DELAY_LO])
         3'h0: delayPeriods = `DLY_CODE0;
         3'h1: delayPeriods = `DLY_CODE1;
         3'h2: delayPeriods = `DLY_CODE2;
         3'h3: delayPeriods = `DLY_CODE3;
         3'h4: delayPeriods = `DLY_CODE4;
         3'h5: delayPeriods = `DLY_CODE5;
         3'h6: delayPeriods = `DLY_CODE6;
         default: delayPeriods = `DLY_CODE7;
      endcase
   end
   assign sif.start   = channelSwitch;
   assign sif.periods = delayPeriods;
   assign settleBusy  = sif.busy;
   assign settleDone  = sif.done;

   settle_counter u_settle (
      .clk     (clk),
      .rstn    (rstn),
      .modTick (modTick),
      .sif     (sif)
   );

   // --------------------------------------------------------------
   // read data, registered
   // --------------------------------------------------------------
   // bit 0 is write-only so it always reads zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 16'h0000;
      end else if (regRead && regAddr == `MODE_REG_ADDR) begin
         regRdata <= mode_ff;
      end else begin
         regRdata <= 16'h0000;
      end
   end
endmodule

// File: bench/mode_ctrl_monitor.sv
`timescale 1ns/1ps
// ----
// mode register port checker
// ----
module mode_ctrl_monitor (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [5:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] regRdata,
   input wire logic        resultWritten,
   input wire logic        refEnable,
   input wire logic        ampRailDetectEnable,
   input wire logic [2:0]  convMode,
   input wire logic [1:0]  clockSourceSelect,
   input wire logic        intOscEnable,
   input wire logic        extClockSelect,
   input wire logic        filterReset,
   input wire logic        convStart,
   input wire logic        newResultReady,
   input wire logic        softwareResetPulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // a reset write reloads defaults, so field checks skip it
   wire wrAny = regWrite && regAddr == 6'h01;
   wire wrMode = wrAny && !regWdata[0];
   a_write_filter: assert property (wrAny |-> filterReset) else $error("no filter reset");
   a_write_start: assert property (wrMode && regWdata[6:5] != 2'b01 |=> convStart)
      else $error("no start after write");
   a_ref_load: assert property (wrMode |=> refEnable == $past(regWdata[15]))
      else $error("reference enable wrong");
   a_rail_load: assert property (wrMode |=> ampRailDetectEnable == $past(regWdata[14]))
      else $error("rail detect wrong");
   a_mode_load: assert property (wrMode |=> convMode == $past(regWdata[6:4]))
      else $error("mode field wrong");
   a_osc_on: assert property (clockSourceSelect != 2'h2 |-> intOscEnable)
      else $error("oscillator off");
   a_ext_clock: assert property (extClockSelect == (clockSourceSelect == 2'h2))
      else $error("external clock select wrong");
   a_flag_set: assert property (resultWritten |=> newResultReady) else $error("flag not set");
   a_flag_clear: assert property ((wrAny || regRead && regAddr == 6'h04) && !resultWritten
      |=> !newResultReady) else $error("flag not cleared");
   a_rsvd_read: assert property (regRead |=> regRdata[12:11] == 2'b00 && !regRdata[0])
      else $error("reserved bits not zero");
   a_reset_len: assert property ($rose(softwareResetPulse)
      |-> softwareResetPulse[*4] ##1 !softwareResetPulse) else $error("reset pulse length");
   c_mode_write: cover property (wrMode);
   c_sw_reset: cover property ($rose(softwareResetPulse));
   c_flag: cover property (newResultReady ##1 !newResultReady);
endmodule
bind converter_mode_control mode_ctrl_monitor mon_u (.clk, .rstn, .regWrite, .regRead, .regAddr,
   .regWdata, .regRdata, .resultWritten, .refEnable, .ampRailDetectEnable, .convMode,
   .clockSourceSelect, .intOscEnable, .extClockSelect, .filterReset, .convStart,
   .newResultReady, .softwareResetPulse);

// File: bench/host_model.sv
`timescale 1ns/1ps
// ----
// host side of the register access
// ----
module host_model (
   input  wire logic        clk,
   input  wire logic [15:0] regRdata,
   output logic             regWrite,
   output logic             regRead,
   output logic      [5:0]  regAddr,
   output logic      [15:0] regWdata
);
   initial regWrite = 1'b0;
   initial regRead = 1'b0;
   // one access per call, address inverted when idle, data inverted too after a write
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d & 16'hE7FF;
      @(negedge clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   task rd(input logic [5:0] a, output logic [15:0] d);
      @(negedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(negedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      d = regRdata;
   endtask
endmodule

// File: bench/test_converter_mode_control.sv
`timescale 1ns/1ps
// ----
// bench for the mode register block
// ----
module test_converter_mode_control;
   logic        clk, rstn, regWrite, regRead, modTick, channelSwitch, resultWritten;
   logic [5:0]  regAddr;
   logic [15:0] regWdata, regRdata, rd;
   logic [2:0]  convMode;
   logic [1:0]  clockSourceSelect;
   logic        refEnable, referenceOutputEnable, ampRailDetectEnable, settledOutputOnly;
   logic        rateDouble, intOscEnable, crystalClockOutEnable, extClockSelect, filterReset;
   logic        convStart, settleBusy, settleDone, newResultReady, softwareResetPulse;
   int          mismatches, checks_done, n, hits;
   int          dly [8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
   host_model host_u (.clk(clk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata));
   converter_mode_control dut_u (.clk(clk), .rstn(rstn), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .modTick(modTick),
      .channelSwitch(channelSwitch), .resultWritten(resultWritten), .refEnable(refEnable),
      .referenceOutputEnable(referenceOutputEnable), .ampRailDetectEnable(ampRailDetectEnable),
      .settledOutputOnly(settledOutputOnly), .rateDouble(rateDouble), .convMode(convMode),
      .clockSourceSelect(clockSourceSelect), .intOscEnable(intOscEnable),
      .crystalClockOutEnable(crystalClockOutEnable), .extClockSelect(extClockSelect),
      .filterReset(filterReset), .convStart(convStart), .settleBusy(settleBusy),
      .settleDone(settleDone), .newResultReady(newResultReady),
      .softwareResetPulse(softwareResetPulse));
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task test_done;
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // modulator tick every second cycle keeps settle waits short
   always @(negedge clk) modTick <= ~modTick;
   // watchdog well past the longest settle wait
   initial begin
      #400000;
      mismatches++;
      test_done;
   end
   initial begin
      {rstn, modTick, channelSwitch, resultWritten, mismatches, checks_done} = '0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      host_u.rd(6'h01, rd);
      chk("mode reset", rd, 16'h2000);
      chk("settled only", settledOutputOnly, 1'b1);
      host_u.wr(6'h01, 16'hC0F8);
      chk("enables", {refEnable, referenceOutputEnable, ampRailDetectEnable, rateDouble}, 4'hF);
      host_u.rd(6'h01, rd);
      chk("readback", rd, 16'hC0F8);
      // every mode code, with the clock source code set to the mode's low two bits
      for (logic [3:0] m = 0; m < 8; m++) begin
         host_u.wr(6'h01, {9'h000, m[2:0], m[1:0], 2'b00});
         chk("mode", {convStart, convMode, intOscEnable, crystalClockOutEnable, extClockSelect},
            {m < 2 || m > 3, m[2:0], m[1:0] != 2, m[1:0] == 1, m[1:0] == 2});
      end
      // each delay code counted in modulator ticks
      for (logic [3:0] d = 0; d < 8; d++) begin
         host_u.wr(6'h01, {5'h00, d[2:0], 8'h20});
         @(negedge clk) channelSwitch <= 1'b1;
         @(negedge clk) channelSwitch <= 1'b0;
         chk("busy", settleBusy, 1'b1);
         // look just after the falling edge, where ticks and counter are settled
         n = 0;
         hits = 0;
         while (settleBusy && n < 5000) begin
            #1;
            if (settleBusy && modTick) n++;
            hits += settleDone;
            @(negedge clk);
         end
         chk("settle ticks", n[15:0], dly[d][15:0]);
         chk("settle done", hits[15:0], 16'h0001);
      end
      @(negedge clk) resultWritten <= 1'b1;
      @(negedge clk) resultWritten <= 1'b0;
      chk("flag set", newResultReady, 1'b1);
      host_u.rd(6'h04, rd);
      chk("flag read clear", newResultReady, 1'b0);
      @(negedge clk) resultWritten <= 1'b1;
      @(negedge clk) resultWritten <= 1'b0;
      host_u.wr(6'h01, 16'h2000);
      chk("flag write clear", newResultReady, 1'b0);
      host_u.wr(6'h05, 16'hFFFF);
      host_u.rd(6'h01, rd);
      chk("other address", rd, 16'h2000);
      host_u.wr(6'h01, 16'hC0F8);
      host_u.wr(6'h01, 16'h0001);
      chk("sw reset", softwareResetPulse, 1'b1);
      repeat (4) @(negedge clk);
      chk("sw reset end", softwareResetPulse, 1'b0);
      host_u.rd(6'h01, rd);
      chk("after sw reset", rd, 16'h2000);
      test_done;
   end
endmodule
